// ### design/abu_pkg.sv
// Package of the address breakpoint unit: register map, fields, reset values.
// Assumes a 32-bit APB with byte addresses four times the register index.
package abu_pkg;
	localparam int unsigned ABU_ADDR_W = 20;
	// Register indices; the byte address is four times the index
	localparam logic [15:0] ABU_IDX_WAIT_EXIT = 16'hfe00;
	localparam logic [15:0] ABU_IDX_ADDR_HIGH = 16'hfe0c;
	localparam logic [15:0] ABU_IDX_ADDR_LOW = 16'hfe0d;
	localparam logic [15:0] ABU_IDX_STAT_CTRL = 16'hfe0e;
	localparam logic [15:0] ABU_IDX_IRQ_STATUS = 16'hfe10;
	localparam logic [15:0] ABU_IDX_IRQ_ENABLE = 16'hfe11;
	localparam logic [15:0] ABU_IDX_IRQ_CLEAR = 16'hfe12;
	// Field positions
	localparam int unsigned ABU_BIT_MATCH_EN = 7;
	localparam int unsigned ABU_BIT_ACTIVE = 6;
	localparam int unsigned ABU_BIT_WAIT_EXIT = 1;
	// Interrupt status bits
	localparam int unsigned ABU_EVT_MATCH = 0;
	localparam int unsigned ABU_EVT_FORCE = 1;
	localparam int unsigned ABU_EVT_WAIT = 2;
	localparam int unsigned ABU_EVT_N = 3;
	// Reset values
	localparam logic [7:0] ABU_RST_BYTE = 8'h00;
	localparam logic [2:0] ABU_RST_EVT = 3'h0;
endpackage

// ### design/abu_rst_sync.sv
// Reset release synchroniser for the breakpoint unit.
// Assumes resetn may drop at any time; release is aligned to clk_sys.
`timescale 1ns/1ps
module abu_rst_sync (
	input wire logic clk_sys,
	input wire logic resetn,
	output logic rstSyncN
);
	logic stage1_q;
	logic stage2_q;

	// Assert at once, release after two edges so no flop sees a ragged release
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			stage1_q <= 1'b0;
			stage2_q <= 1'b0;
		end else begin
			stage1_q <= 1'b1;
			stage2_q <= stage1_q;
		end
	end

	assign rstSyncN = stage2_q;
endmodule

// ### design/abu_evt_irq.sv
// Sticky event status, enable and write-one-to-clear, merged to one level irq.
// Assumes event pulses and register strobes come from the clk_sys domain.
`timescale 1ns/1ps
module abu_evt_irq (
	input wire logic clk_sys,
	input wire logic rstN,
	input wire logic [abu_pkg::ABU_EVT_N-1:0] evtPulse,
	input wire logic enWrite,
	input wire logic clrWrite,
	input wire logic [abu_pkg::ABU_EVT_N-1:0] wrData,
	output logic [abu_pkg::ABU_EVT_N-1:0] status,
	output logic [abu_pkg::ABU_EVT_N-1:0] enable,
	output logic irq
);
	logic [abu_pkg::ABU_EVT_N-1:0] status_q;
	logic [abu_pkg::ABU_EVT_N-1:0] status_d;
	logic [abu_pkg::ABU_EVT_N-1:0] enable_q;
	wire [abu_pkg::ABU_EVT_N-1:0] clrMask = clrWrite ? wrData : '0;

	// A new event outranks a clear in the same cycle
	assign status_d = (status_q & ~clrMask) | evtPulse;

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			status_q <= abu_pkg::ABU_RST_EVT;
			enable_q <= abu_pkg::ABU_RST_EVT;
		end else begin
			status_q <= status_d;
			if (enWrite) begin
				enable_q <= wrData;
			end
		end
	end

	assign status = status_q;
	assign enable = enable_q;
	assign irq = |(status_q & enable_q);
endmodule

// ### design/abu_top.sv
// Address breakpoint unit: breakpoint address bytes, status/control, wait-exit flag,
// event interrupt block and an APB slave. Assumes the CPU address, its valid strobe
// and the wait indication come from logic on clk_sys, so they are not synchronised.
// Notes on behaviour
// - A CPU address equal to the breakpoint address sets the break-active flag.
// - Software writing one to the break-active flag raises a break request.
// - Reset clears the break-active flag; it reads one after a match or a software force, else zero.
// - The breakpoint address is held as a high byte and a low byte.
// - Both breakpoint address bytes reset to zero.
// - A break that ends wait mode sets the wait-exit flag.
// - Writing zero clears the wait-exit flag; writing one leaves it alone.
`timescale 1ns/1ps
module abu_top (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [abu_pkg::ABU_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] cpuAddr,
	input wire logic cpuAddrValid,
	input wire logic cpuWaitMode,
	output logic breakReq,
	output logic waitExitReq,
	output logic irq
);
	logic rstN;
	logic [7:0] addrHigh_q;
	logic [7:0] addrLow_q;
	logic matchEnable_q;
	logic breakActive_q;
	logic breakActive_d;
	logic waitExit_q;
	logic waitExit_d;
	logic [31:0] prdata_q;
	logic [abu_pkg::ABU_EVT_N-1:0] evtStatus;
	logic [abu_pkg::ABU_EVT_N-1:0] evtEnable;
	logic [abu_pkg::ABU_EVT_N-1:0] evtPulse;

	// Register hit test, shared by every register decode below
	function automatic logic regHit(input logic [abu_pkg::ABU_ADDR_W-1:0] a, input logic [15:0] idx);
		regHit = (a[1:0] == 2'h0) && (a[abu_pkg::ABU_ADDR_W-1:2] == {2'h0, idx});
	endfunction

	abu_rst_sync uRst (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.rstSyncN(rstN)
	);

	// Bus phase decode; zero wait states, so every access completes in its first access cycle
	wire setupPhase = psel && !penable;
	wire accessPhase = psel && penable;
	wire hitWaitExit = regHit(paddr, abu_pkg::ABU_IDX_WAIT_EXIT);
	wire hitHigh = regHit(paddr, abu_pkg::ABU_IDX_ADDR_HIGH);
	wire hitLow = regHit(paddr, abu_pkg::ABU_IDX_ADDR_LOW);
	wire hitCtrl = regHit(paddr, abu_pkg::ABU_IDX_STAT_CTRL);
	wire hitIrqSt = regHit(paddr, abu_pkg::ABU_IDX_IRQ_STATUS);
	wire hitIrqEn = regHit(paddr, abu_pkg::ABU_IDX_IRQ_ENABLE);
	wire hitIrqClr = regHit(paddr, abu_pkg::ABU_IDX_IRQ_CLEAR);
	wire anyHit = hitWaitExit | hitHigh | hitLow | hitCtrl | hitIrqSt | hitIrqEn | hitIrqClr;
	wire wrStrobe = accessPhase && pwrite && anyHit;
	wire wrHigh = wrStrobe && hitHigh;
	wire wrLow = wrStrobe && hitLow;
	wire wrCtrl = wrStrobe && hitCtrl;
	wire wrWaitExit = wrStrobe && hitWaitExit;

	assign pready = 1'b1;
	assign pslverr = accessPhase && !anyHit; // Unmapped index answers with an error

	// Match against the programmed target, gated by the enable bit
	wire [15:0] bkptAddr = {addrHigh_q, addrLow_q};
	wire addrMatch = matchEnable_q && cpuAddrValid && (cpuAddr == bkptAddr);
	wire swForce = wrCtrl && pwdata[abu_pkg::ABU_BIT_ACTIVE];
	wire swClear = wrCtrl && !pwdata[abu_pkg::ABU_BIT_ACTIVE];
	wire breakEvent = addrMatch || swForce;

	// Set wins over a software clear in the same cycle so a match is never lost
	assign breakActive_d = addrMatch ? 1'b1 :
		swForce ? 1'b1 :
		swClear ? 1'b0 : breakActive_q;

	// A break taken while the core waits records the wait exit
	wire waitExitSet = breakEvent && cpuWaitMode;
	wire waitExitClr = wrWaitExit && !pwdata[abu_pkg::ABU_BIT_WAIT_EXIT];
	assign waitExit_d = waitExitSet ? 1'b1 : (waitExitClr ? 1'b0 : waitExit_q);

	// Breakpoint address bytes
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			addrHigh_q <= abu_pkg::ABU_RST_BYTE;
			addrLow_q <= abu_pkg::ABU_RST_BYTE;
		end else begin
			if (wrHigh) begin
				addrHigh_q <= pwdata[7:0];
			end
			if (wrLow) begin
				addrLow_q <= pwdata[7:0];
			end
		end
	end

	// Status/control flags; only bits 7 and 6 exist, the rest are never stored
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			matchEnable_q <= 1'b0;
			breakActive_q <= 1'b0;
			waitExit_q <= 1'b0;
		end else begin
			if (wrCtrl) begin
				matchEnable_q <= pwdata[abu_pkg::ABU_BIT_MATCH_EN];
			end
			breakActive_q <= breakActive_d;
			waitExit_q <= waitExit_d;
		end
	end

	// Read mux for all registers: unimplemented bits read zero
	wire [7:0] ctrlRead = {matchEnable_q, breakActive_q, 6'h00};
	wire [7:0] waitRead = {6'h00, waitExit_q, 1'b0};
	wire [31:0] readMux = hitHigh ? {24'h000000, addrHigh_q} :
		hitLow ? {24'h000000, addrLow_q} :
		hitCtrl ? {24'h000000, ctrlRead} :
		hitWaitExit ? {24'h000000, waitRead} :
		hitIrqSt ? {29'h00000000, evtStatus} :
		hitIrqEn ? {29'h00000000, evtEnable} : 32'h00000000;

	// Read data captured in the setup cycle so it is stable through the access
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			prdata_q <= 32'h00000000;
		end else if (setupPhase && !pwrite) begin
			prdata_q <= readMux;
		end
	end

	assign prdata = prdata_q;
	assign breakReq = breakActive_q;
	assign waitExitReq = waitExit_q;

	// Events: first cycle of a match, a software force, and a wait exit
	assign evtPulse[abu_pkg::ABU_EVT_MATCH] = addrMatch && !breakActive_q;
	assign evtPulse[abu_pkg::ABU_EVT_FORCE] = swForce;
	assign evtPulse[abu_pkg::ABU_EVT_WAIT] = waitExitSet && !waitExit_q;

	abu_evt_irq uIrq (
		.clk_sys(clk_sys),
		.rstN(rstN),
		.evtPulse(evtPulse),
		.enWrite(wrStrobe && hitIrqEn),
		.clrWrite(wrStrobe && hitIrqClr),
		.wrData(pwdata[abu_pkg::ABU_EVT_N-1:0]),
		.status(evtStatus),
		.enable(evtEnable),
		.irq(irq)
	);

	// Checks on the flags and the bus; all on clk_sys, disabled in reset
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstN);

	match_sets_a: assert property (addrMatch |=> breakActive_q)
		else $error("address match did not set break-active flag");
	force_sets_a: assert property (swForce |=> breakActive_q && breakReq)
		else $error("software force did not raise break request");
	clear_works_a: assert property (swClear && !addrMatch |=> !breakActive_q)
		else $error("writing zero did not clear break-active flag");
	active_read_a: assert property (setupPhase && !pwrite && hitCtrl
		|=> prdata[abu_pkg::ABU_BIT_ACTIVE] == $past(breakActive_q))
		else $error("break-active flag read back wrong");
	low_byte_a: assert property (wrLow ##1 (psel && !penable && !pwrite && hitLow)
		|=> prdata[7:0] == $past(pwdata[7:0], 2))
		else $error("low address byte did not read back");
	target_a: assert property (bkptAddr == {addrHigh_q, addrLow_q} && $rose(rstN)
		|-> bkptAddr == 16'h0000)
		else $error("breakpoint address not zero after reset");
	wait_exit_a: assert property (breakEvent && cpuWaitMode |=> waitExitReq)
		else $error("break in wait mode did not set wait-exit flag");
	wait_keep_a: assert property (wrWaitExit && pwdata[abu_pkg::ABU_BIT_WAIT_EXIT] && waitExit_q
		|=> waitExit_q)
		else $error("writing one changed the wait-exit flag");
	wait_clear_a: assert property (waitExitClr && !waitExitSet |=> !waitExit_q)
		else $error("writing zero did not clear the wait-exit flag");
	enable_gate_a: assert property (!matchEnable_q && !swForce && !breakActive_q
		|=> !breakActive_q)
		else $error("break-active set while matching disabled");
	unimpl_zero_a: assert property (setupPhase && !pwrite && hitCtrl |=> prdata[5:0] == 6'h00)
		else $error("unimplemented status/control bits read nonzero");
	irq_level_a: assert property (irq == |(evtStatus & evtEnable))
		else $error("interrupt output disagrees with status and enable");

	match_seen_c: cover property (addrMatch ##1 breakReq ##[1:20] swClear);
	force_seen_c: cover property (swForce ##1 breakReq);
	wait_seen_c: cover property (waitExitSet ##[1:20] waitExitClr);
	irq_seen_c: cover property ($rose(irq));
endmodule

// ### sim/abu_cpu_model.sv
// CPU-side partner of the breakpoint unit: drives the address bus and wait mode.
// Assumes the bench calls show() from its main sequence, one call at a time.
`timescale 1ns/1ps
module abu_cpu_model (
	input wire logic clk_sys,
	output logic [15:0] cpuAddr,
	output logic cpuAddrValid,
	output logic cpuWaitMode
);
	initial begin
		cpuAddr = 16'hffff;
		cpuAddrValid = 1'b0;
		cpuWaitMode = 1'b0;
	end
	// One qualified address after a gap; the bus flips afterwards so no stale value can match
	task automatic show(input logic [15:0] addr, input logic waitMode, input int gap);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		cpuAddr <= addr;
		cpuAddrValid <= 1'b1;
		cpuWaitMode <= waitMode;
		@(posedge clk_sys);
		cpuAddrValid <= 1'b0;
		cpuAddr <= ~addr;
		cpuWaitMode <= 1'b0;
	endtask
endmodule

// ### sim/abu_top_tb.sv
// Self-checking bench for the breakpoint unit: APB master, CPU model, scenario tasks.
// Assumes zero-wait APB answers and a one-cycle match-to-flag delay.
`timescale 1ns/1ps
module abu_top_tb;
	logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, breakReq, waitExitReq, irq, err;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] cpuAddr;
	logic cpuAddrValid, cpuWaitMode;
	int miscompares = 0;
	int checkCount = 0;
	int cycles = 0;
	abu_top u_abu_top (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuAddr(cpuAddr),
		.cpuAddrValid(cpuAddrValid), .cpuWaitMode(cpuWaitMode), .breakReq(breakReq), .waitExitReq(waitExitReq),
		.irq(irq));
	abu_cpu_model u_abu_cpu_model (.clk_sys(clk_sys), .cpuAddr(cpuAddr), .cpuAddrValid(cpuAddrValid),
		.cpuWaitMode(cpuWaitMode));
	// Free-running clock, 4 ns period
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Hang guard: the sequence needs well under 1000 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask
	// Flags are looked at half a cycle after the edge, so the value launched by that edge has settled
	task automatic chk_bit(ref logic got, input logic exp);
		@(negedge clk_sys);
		checkCount++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	// One APB transfer; request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk_word(rd, {24'h000000, exp});
	endtask
	task automatic do_reset();
		resetn <= 1'b0;
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask
	// Loaded registers and a set flag all return to zero on a mid-run reset
	task automatic t_reset_mid();
		apb(1'b1, abu_pkg::ABU_IDX_ADDR_HIGH, 8'h3c);
		apb(1'b1, abu_pkg::ABU_IDX_STAT_CTRL, 8'hc0);
		do_reset();
		chk_bit(breakReq, 1'b0);
		rd_chk(abu_pkg::ABU_IDX_ADDR_HIGH, 8'h00);
		rd_chk(abu_pkg::ABU_IDX_ADDR_LOW, 8'h00);
		rd_chk(abu_pkg::ABU_IDX_STAT_CTRL, 8'h00);
	endtask
	// Target bytes read back apart; low six control bits ignore writes
	task automatic t_regs();
		apb(1'b1, abu_pkg::ABU_IDX_ADDR_HIGH, 8'ha5);
		apb(1'b1, abu_pkg::ABU_IDX_ADDR_LOW, 8'h5a);
		rd_chk(abu_pkg::ABU_IDX_ADDR_HIGH, 8'ha5);
		rd_chk(abu_pkg::ABU_IDX_ADDR_LOW, 8'h5a);
		apb(1'b1, abu_pkg::ABU_IDX_STAT_CTRL, 8'hbf);
		rd_chk(abu_pkg::ABU_IDX_STAT_CTRL, 8'h80);
		apb(1'b1, abu_pkg::ABU_IDX_IRQ_ENABLE, 8'h07);
	endtask
	// A near miss leaves the flag low, the exact target sets it; handler clears it
	task automatic t_match();
		u_abu_cpu_model.show(16'ha55b, 1'b0, 0);
		@(negedge clk_sys);
		chk_bit(breakReq, 1'b0);
		u_abu_cpu_model.show(16'ha55a, 1'b0, 3);
		@(negedge clk_sys);
		chk_bit(breakReq, 1'b1);
		chk_bit(irq, 1'b1);
		rd_chk(abu_pkg::ABU_IDX_STAT_CTRL, 8'hc0);
		apb(1'b1, abu_pkg::ABU_IDX_STAT_CTRL, 8'h80);
		apb(1'b1, abu_pkg::ABU_IDX_IRQ_CLEAR, 8'h07);
		chk_bit(breakReq, 1'b0);
		chk_bit(irq, 1'b0);
	endtask
	// With matching disabled the target passes unnoticed
	task automatic t_disabled();
		apb(1'b1, abu_pkg::ABU_IDX_STAT_CTRL, 8'h00);
		u_abu_cpu_model.show(16'ha55a, 1'b0, 0);
		@(negedge clk_sys);
		chk_bit(breakReq, 1'b0);
		rd_chk(abu_pkg::ABU_IDX_STAT_CTRL, 8'h00);
	endtask
	// Software-forced break, masked and then unmasked interrupt, clear
	task automatic t_force();
		apb(1'b1, abu_pkg::ABU_IDX_IRQ_ENABLE, 8'h00);
		apb(1'b1, abu_pkg::ABU_IDX_STAT_CTRL, 8'h40);
		chk_bit(breakReq, 1'b1);
		chk_bit(irq, 1'b0);
		rd_chk(abu_pkg::ABU_IDX_IRQ_STATUS, 8'h02);
		apb(1'b1, abu_pkg::ABU_IDX_IRQ_ENABLE, 8'h02);
		chk_bit(irq, 1'b1);
		apb(1'b1, abu_pkg::ABU_IDX_IRQ_CLEAR, 8'h02);
		chk_bit(irq, 1'b0);
		apb(1'b1, abu_pkg::ABU_IDX_STAT_CTRL, 8'h80);
		chk_bit(breakReq, 1'b0);
	endtask
	// Break in wait mode sets the exit flag; writing one keeps it, zero clears it
	task automatic t_wait();
		u_abu_cpu_model.show(16'ha55a, 1'b1, 2);
		@(negedge clk_sys);
		chk_bit(waitExitReq, 1'b1);
		rd_chk(abu_pkg::ABU_IDX_WAIT_EXIT, 8'h02);
		apb(1'b1, abu_pkg::ABU_IDX_WAIT_EXIT, 8'h02);
		chk_bit(waitExitReq, 1'b1);
		apb(1'b1, abu_pkg::ABU_IDX_WAIT_EXIT, 8'h00);
		chk_bit(waitExitReq, 1'b0);
		apb(1'b1, abu_pkg::ABU_IDX_STAT_CTRL, 8'h80);
	endtask
	// Unmapped index answers with an error and zero data
	task automatic t_unmapped();
		rd_chk(16'hfe05, 8'h00);
		chk_bit(err, 1'b1);
	endtask
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 20'h00000;
		pwdata = 32'h00000000;
		do_reset();
		rd_chk(abu_pkg::ABU_IDX_WAIT_EXIT, 8'h00);
		t_reset_mid();
		t_regs();
		t_match();
		t_disabled();
		t_force();
		apb(1'b1, abu_pkg::ABU_IDX_STAT_CTRL, 8'h80);
		t_wait();
		t_unmapped();
		end_sim();
	end
endmodule
